// ==== verilog/cfp_pkg.sv ====
// Constants, types and register map of the converter fault supervisor.
package cfp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ      = 50;
	localparam int DELAY_US     = 6;
	localparam int DELAY_CYC    = DELAY_US * CLK_MHZ;
	localparam int OT_DELAY_MS  = 2;
	localparam int OT_DELAY_CYC = OT_DELAY_MS * 1000 * CLK_MHZ;
	localparam int RETRY_MS     = 130;
	localparam int RETRY_CYC    = RETRY_MS * 1000 * CLK_MHZ;

	// ==========================================================
	// Thresholds
	localparam logic [7:0]        UV_PCT_BASE = 8'h4B;
	localparam logic [7:0]        PCT_STEP5   = 8'h05;
	localparam logic [7:0]        PG_PCT_BASE = 8'h5A;
	localparam logic [7:0]        PG_PCT_HIGH = 8'h6E;
	localparam logic [7:0]        OV_PCT_BASE = 8'h6E;
	localparam logic [7:0]        OV_PCT_STEP = 8'h0A;
	localparam logic [16:0]       OV_MIN_MV   = 17'h0_03E8;
	localparam logic [16:0]       TRK_WIN_MV  = 17'h0_00FA;
	localparam logic signed [9:0] OT_OFF_C    = 10'sh078;
	localparam logic signed [9:0] OT_ON_C     = 10'sh06E;
	localparam logic signed [9:0] WARN_ON_C   = 10'sh078;
	localparam logic signed [9:0] WARN_HYST_C = 10'sh003;

	// ==========================================================
	// Register map
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
	localparam logic [7:0] OFS_OV_LEVEL = 8'h10;
	localparam logic [7:0] OFS_CLEAR    = 8'h14;
	localparam int         CLEAR_BIT    = 0;

	typedef struct packed {
		logic [1:0] ov_sel;
		logic       trk_latch;
		logic       trk_en;
		logic       ot_latch;
		logic       uv_latch;
		logic       pg_sel;
		logic [1:0] uv_sel;
	} cfp_ctrl_type;

	localparam logic [8:0] CTRL_RST = 9'h000;

	// Event and filter channel numbering, shared by status and interrupts.
	localparam int CH_UV   = 0;
	localparam int CH_TRK  = 1;
	localparam int CH_OT   = 2;
	localparam int CH_WARN = 3;
	localparam int CH_PG   = 4;
	localparam int NUM_CH  = 5;

	typedef struct packed {
		logic [1:0] state;
		logic       turn_off;
		logic       pg;
		logic       warn;
		logic       ot_fault;
		logic       trk_fault;
		logic       uv_fault;
	} cfp_status_type;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_RETRY = 2'b01,
		ST_LATCH = 2'b11
	} cfp_state_type;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ==== verilog/cfp_top.sv ====
// Converter fault supervisor with AXI4-Lite registers and interrupt.
`timescale 1ns/1ps
module cfp_top #(
	parameter int OT_DELAY_CYC = cfp_pkg::OT_DELAY_CYC,
	parameter int RETRY_CYC    = cfp_pkg::RETRY_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [15:0]       vout_mv,
	input  wire logic [15:0]       vset_mv,
	input  wire logic [15:0]       vref_mv,
	input  wire logic              ramping_up,
	input  wire logic signed [9:0] temp_c,
	output logic                   turn_off,
	output logic                   output_in_window_pin,
	output logic [16:0]            overvoltage_trip,
	output logic                   irq,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);
	import cfp_pkg::*;

	function automatic logic [16:0] pct_of(input logic [15:0] v, input logic [7:0] p);
		logic [23:0] prod;
		prod = v * p;
		return 17'(prod / 24'd100);
	endfunction

	// ==========================================================
	// Registers
	cfp_ctrl_type        ctrl_q;
	logic [NUM_CH-1:0]   irq_stat_q;
	logic [NUM_CH-1:0]   irq_mask_q;
	logic [NUM_CH-1:0]   filt_q;
	logic [NUM_CH-1:0]   filt_prev_q;
	logic [31:0]         fcnt_q [NUM_CH];
	cfp_state_type       state_q;
	cfp_state_type       state_d;
	logic [2:0]          cause_q;
	logic [31:0]         retry_cnt_q;
	logic [16:0]         ov_level_q;
	logic                irq_q;
	logic                turn_off_q;
	logic                awready_q;
	logic                wready_q;
	logic                bvalid_q;
	logic [1:0]          bresp_q;
	logic                arready_q;
	logic                rvalid_q;
	logic [31:0]         rdata_q;
	logic [1:0]          rresp_q;
	logic                aw_hold_q;
	logic                w_hold_q;
	logic [7:0]          aw_addr_q;
	logic [31:0]         w_data_q;
	logic [3:0]          w_strb_q;

	// ==========================================================
	// Thresholds
	wire logic [7:0]  uv_pct   = UV_PCT_BASE + 8'(ctrl_q.uv_sel * PCT_STEP5);
	wire logic [7:0]  pg_pct   = ctrl_q.pg_sel ? PG_PCT_BASE + PCT_STEP5 : PG_PCT_BASE;
	wire logic [7:0]  ov_pct   = OV_PCT_BASE + 8'(ctrl_q.ov_sel * OV_PCT_STEP);
	wire logic [16:0] vout_x   = {1'b0, vout_mv};
	wire logic [16:0] vref_x   = {1'b0, vref_mv};
	wire logic [16:0] uv_thr   = pct_of(vset_mv, uv_pct);
	wire logic [16:0] pg_lo    = pct_of(vset_mv, pg_pct);
	wire logic [16:0] pg_hi    = pct_of(vset_mv, PG_PCT_HIGH);
	wire logic [16:0] ov_raw   = pct_of(vset_mv, ov_pct);
	wire logic [16:0] ov_clamp = (ov_raw < OV_MIN_MV) ? OV_MIN_MV : ov_raw;
	wire logic [16:0] trk_diff = (vout_x > vref_x) ? vout_x - vref_x : vref_x - vout_x;

	// ==========================================================
	// Raw conditions
	wire logic running  = (state_q == ST_RUN);
	wire logic uv_raw   = running & ~ramping_up & (vout_x < uv_thr);
	wire logic trk_raw  = running & ctrl_q.trk_en & ramping_up & (trk_diff > TRK_WIN_MV);
	wire logic ot_raw   = (temp_c >= OT_OFF_C);
	wire logic ot_cool  = (temp_c <= OT_ON_C);
	// The warning keeps its own filtered state as the hysteresis memory.
	wire logic warn_raw = filt_q[CH_WARN] ? (temp_c > WARN_ON_C - WARN_HYST_C)
	                                      : (temp_c >= WARN_ON_C);
	wire logic pg_raw   = (vout_x >= pg_lo) & (vout_x <= pg_hi);
	wire logic [NUM_CH-1:0] raw = {pg_raw, warn_raw, ot_raw, trk_raw, uv_raw};

	// ==========================================================
	// Delay filters
	// Each channel follows its raw condition only after the condition has held
	// without a break for the channel's delay, so short glitches never act.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_filt
			localparam int LIM = (gi == CH_OT) ? OT_DELAY_CYC : DELAY_CYC;
			wire logic done = (fcnt_q[gi] >= 32'(LIM - 1));
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					fcnt_q[gi] <= 32'h0000_0000;
					filt_q[gi] <= 1'b0;
				end
				else if (raw[gi] == filt_q[gi])
					fcnt_q[gi] <= 32'h0000_0000;
				else if (done)
				begin
					fcnt_q[gi] <= 32'h0000_0000;
					filt_q[gi] <= raw[gi];
				end
				else
					fcnt_q[gi] <= fcnt_q[gi] + 32'h0000_0001;
			end
		end
	endgenerate

	// ==========================================================
	// Fault sequencer
	wire logic       trip_uv   = running & filt_q[CH_UV];
	wire logic       trip_trk  = running & filt_q[CH_TRK];
	wire logic       trip_ot   = running & filt_q[CH_OT];
	wire logic       any_trip  = trip_uv | trip_trk | trip_ot;
	wire logic [2:0] new_cause = {trip_ot, trip_trk, trip_uv};
	wire logic       latch_it  = (trip_uv & ctrl_q.uv_latch) | (trip_trk & ctrl_q.trk_latch)
	                           | (trip_ot & ctrl_q.ot_latch);
	wire logic       retry_end = (retry_cnt_q >= 32'(RETRY_CYC - 1));
	wire logic       ot_ok     = ot_cool & ~filt_q[CH_OT];
	wire logic       resume    = cause_q[CH_OT] ? (ot_ok & retry_end) : retry_end;

	// ==========================================================
	// AXI4-Lite decode
	wire logic aw_fire  = s_axi_awvalid & awready_q;
	wire logic w_fire   = s_axi_wvalid & wready_q;
	wire logic do_write = aw_hold_q & w_hold_q & ~bvalid_q;
	wire logic aw_hold_d = (aw_hold_q | aw_fire) & ~do_write;
	wire logic w_hold_d  = (w_hold_q | w_fire) & ~do_write;
	wire logic bvalid_d  = do_write | (bvalid_q & ~s_axi_bready);
	wire logic ar_fire  = s_axi_arvalid & arready_q;
	wire logic rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);
	wire logic [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
	                           {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire logic [31:0] wbits = w_data_q & wmask;
	wire logic wr_ctrl   = do_write & (aw_addr_q == OFS_CTRL);
	wire logic wr_istat  = do_write & (aw_addr_q == OFS_IRQ_STAT);
	wire logic wr_imask  = do_write & (aw_addr_q == OFS_IRQ_MASK);
	wire logic wr_clear  = do_write & (aw_addr_q == OFS_CLEAR) & wbits[CLEAR_BIT];
	wire logic wr_ro     = (aw_addr_q == OFS_STATUS) | (aw_addr_q == OFS_OV_LEVEL);
	wire logic wr_ok     = (aw_addr_q == OFS_CTRL) | (aw_addr_q == OFS_IRQ_STAT)
	                     | (aw_addr_q == OFS_IRQ_MASK) | (aw_addr_q == OFS_CLEAR) | wr_ro;
	wire logic [8:0] ctrl_bits = 9'(ctrl_q);
	wire logic [8:0] ctrl_d = (ctrl_bits & ~wmask[8:0]) | wbits[8:0];

	cfp_status_type status;
	assign status = '{state: state_q, turn_off: turn_off_q, pg: filt_q[CH_PG],
	                  warn: filt_q[CH_WARN], ot_fault: cause_q[CH_OT],
	                  trk_fault: cause_q[CH_TRK], uv_fault: cause_q[CH_UV]};

	wire logic rd_hit = (s_axi_araddr == OFS_CTRL) | (s_axi_araddr == OFS_STATUS)
	                  | (s_axi_araddr == OFS_IRQ_STAT) | (s_axi_araddr == OFS_IRQ_MASK)
	                  | (s_axi_araddr == OFS_OV_LEVEL) | (s_axi_araddr == OFS_CLEAR);
	wire logic [31:0] rd_word =
		(s_axi_araddr == OFS_CTRL)     ? {23'h00_0000, ctrl_bits} :
		(s_axi_araddr == OFS_STATUS)   ? {24'h00_0000, 8'(status)} :
		(s_axi_araddr == OFS_IRQ_STAT) ? {27'h000_0000, irq_stat_q} :
		(s_axi_araddr == OFS_IRQ_MASK) ? {27'h000_0000, irq_mask_q} :
		(s_axi_araddr == OFS_OV_LEVEL) ? {15'h0000, ov_level_q} : 32'h0000_0000;

	// ==========================================================
	// Interrupt events
	wire logic [NUM_CH-1:0] ev = {filt_q[CH_PG] ^ filt_prev_q[CH_PG],
	                              filt_q[CH_WARN] & ~filt_prev_q[CH_WARN],
	                              trip_ot, trip_trk, trip_uv};
	wire logic [NUM_CH-1:0] ist_clr = wr_istat ? wbits[NUM_CH-1:0] : '0;
	// A new event in the cycle of its clear survives the clear.
	wire logic [NUM_CH-1:0] irq_stat_d = ev | (irq_stat_q & ~ist_clr);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
				if (any_trip)
					state_d = latch_it ? ST_LATCH : ST_RETRY;
			ST_RETRY:
				if (resume)
					state_d = ST_RUN;
			ST_LATCH:
				if (wr_clear)
					state_d = ST_RUN;
			default:
				state_d = ST_LATCH;
		endcase
	end

	// ==========================================================
	// Sequential logic
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q     <= ST_RUN;
			cause_q     <= 3'h0;
			retry_cnt_q <= 32'h0000_0000;
			turn_off_q  <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			turn_off_q  <= (state_d != ST_RUN);
			if (state_q == ST_RUN && any_trip)
				cause_q <= new_cause;
			else if (state_d == ST_RUN)
				cause_q <= 3'h0;
			if (state_q == ST_RETRY && !retry_end)
				retry_cnt_q <= retry_cnt_q + 32'h0000_0001;
			else if (state_q != ST_RETRY)
				retry_cnt_q <= 32'h0000_0000;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q      <= cfp_ctrl_type'(CTRL_RST);
			irq_stat_q  <= '0;
			irq_mask_q  <= '0;
			filt_prev_q <= '0;
			ov_level_q  <= OV_MIN_MV;
			irq_q       <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= cfp_ctrl_type'(ctrl_d);
			if (wr_imask)
				irq_mask_q <= (irq_mask_q & ~wmask[NUM_CH-1:0]) | wbits[NUM_CH-1:0];
			irq_stat_q  <= irq_stat_d;
			filt_prev_q <= filt_q;
			ov_level_q  <= ov_clamp;
			irq_q       <= |(irq_stat_d & irq_mask_q);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end
		else
		begin
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			awready_q <= ~aw_hold_d & ~bvalid_d;
			wready_q  <= ~w_hold_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (aw_fire)
				aw_addr_q <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write)
				bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			if (ar_fire)
			begin
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// Outputs
	assign turn_off             = turn_off_q;
	assign output_in_window_pin = filt_q[CH_PG];
	assign overvoltage_trip     = ov_level_q;
	assign irq                  = irq_q;
	assign s_axi_awready        = awready_q;
	assign s_axi_wready         = wready_q;
	assign s_axi_bvalid         = bvalid_q;
	assign s_axi_bresp          = bresp_q;
	assign s_axi_arready        = arready_q;
	assign s_axi_rvalid         = rvalid_q;
	assign s_axi_rdata          = rdata_q;
	assign s_axi_rresp          = rresp_q;

endmodule

// ==== verif/cfp_monitor.sv ====
// Port-level assertion checker for the converter fault supervisor.
`timescale 1ns/1ps
module cfp_monitor #(
	parameter int OT_DELAY_CYC = 20,
	parameter int RETRY_CYC    = 50
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [15:0]       vout_mv,
	input wire logic [15:0]       vset_mv,
	input wire logic              ramping_up,
	input wire logic signed [9:0] temp_c,
	input wire logic              turn_off,
	input wire logic              output_in_window_pin,
	input wire logic [16:0]       overvoltage_trip,
	input wire logic [7:0]        s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready
);
	import cfp_pkg::*;
	// ==========================================================
	// Run-length counters
	// The fault counter takes any ramp as a possible tracking fault, so it can only overcount.
	localparam int FMIN = OT_DELAY_CYC < 300 ? OT_DELAY_CYC : 300;
	wire [31:0] v    = 32'(vout_mv);
	wire [31:0] l90  = vset_mv * 90 / 100;
	wire [31:0] l95  = vset_mv * 95 / 100;
	wire [31:0] h110 = vset_mv * 110 / 100;
	wire        flt  = (v < l90) || ramping_up || temp_c >= OT_OFF_C;
	int         win_q, out_q, flt_q, off_q;
	logic       clr_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			win_q <= 0;
			out_q <= 0;
			flt_q <= 0;
			off_q <= 0;
			clr_q <= 1'h0;
		end
		else
		begin
			win_q <= (v >= l90 && v <= h110) ? win_q + 1 : 0;
			out_q <= (v < l95 || v > h110) ? out_q + 1 : 0;
			flt_q <= flt ? flt_q + 1 : 0;
			off_q <= turn_off ? off_q + 1 : 0;
			clr_q <= (clr_q && turn_off) ||
				(s_axi_awvalid && s_axi_awready && s_axi_awaddr == OFS_CLEAR);
		end
	end
	// ==========================================================
	// Assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_ov_floor: assert property (overvoltage_trip >= OV_MIN_MV)
		else $error("Overvoltage level below floor");
	chk_ov_ratio: assert property (aresetn |=> 32'(overvoltage_trip) >= $past(h110))
		else $error("Overvoltage level below set ratio");
	chk_pg_rise: assert property ($rose(output_in_window_pin) |-> win_q >= 300)
		else $error("Power good rose too early");
	chk_pg_fall: assert property ($fell(output_in_window_pin) |-> out_q >= 300)
		else $error("Power good fell too early");
	chk_off_cause: assert property ($rose(turn_off) |-> flt_q >= FMIN)
		else $error("Turn off without filtered fault");
	chk_off_retry: assert property ($fell(turn_off) |-> off_q >= RETRY_CYC || clr_q)
		else $error("Turn on before retry or clear");
	chk_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read answer late");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("Read answer dropped");
	chk_ar_shut: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read address open while answering");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("Write response dropped");
endmodule
bind cfp_top cfp_monitor #(
	.OT_DELAY_CYC(OT_DELAY_CYC),
	.RETRY_CYC(RETRY_CYC)
) mon (
	.aclk, .aresetn, .vout_mv, .vset_mv, .ramping_up, .temp_c, .turn_off,
	.output_in_window_pin, .overvoltage_trip, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// ==== verif/cfp_stage_model.sv ====
// Behavioural power stage whose output follows a target unless commanded off.
`timescale 1ns/1ps
module cfp_stage_model (
	input  wire logic        aclk,
	input  wire logic        turn_off,
	input  wire logic [15:0] target_mv,
	output logic      [15:0] vout_mv
);
	// A stage that is off discharges the rail, so a restart re-checks from a dead output.
	initial vout_mv = 16'h0000;
	always @(posedge aclk)
		vout_mv <= turn_off ? 16'h0000 : target_mv;
endmodule

// ==== verif/testbench.sv ====
// Self-checking testbench of the converter fault supervisor.
`timescale 1ns/1ps
module testbench;
	import cfp_pkg::*;
	typedef struct packed {logic [15:0] vs; logic [1:0] sel; logic [31:0] ov;} cfp_row_type;
	cfp_row_type rows [5] = '{'{16'h03E8, 2'h0, 32'h0000_044C}, '{16'h0320, 2'h0, 32'h0000_03E8},
		'{16'h09C4, 2'h1, 32'h0000_0BB8}, '{16'h07D0, 2'h3, 32'h0000_0AF0},
		'{16'h09C4, 2'h2, 32'h0000_0CB2}};
	logic [7:0]        rd_list [4] = '{OFS_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_CLEAR};
	logic              aclk, turn_off, output_in_window_pin, irq;
	logic              aresetn = 1'h0, ramping_up = 1'h0;
	logic [15:0]       vout_mv, vset_mv = 16'h03E8, vref_mv = 16'h03E8, target = 16'h03E8;
	logic signed [9:0] temp_c = 10'sh019;
	logic [16:0]       overvoltage_trip;
	logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
	logic [3:0]        s_axi_wstrb = 4'hF;
	logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	int                fail_count = 0, cmp_count = 0;
	wire [2:0]         obs = {irq, output_in_window_pin, turn_off};
	// Retry outlasts the 300-cycle filters, so a restart never meets a stale trip.
	cfp_top #(.OT_DELAY_CYC(20), .RETRY_CYC(400)) dut (.aclk, .aresetn, .vout_mv, .vset_mv,
		.vref_mv, .ramping_up, .temp_c, .turn_off, .output_in_window_pin, .overvoltage_trip,
		.irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	cfp_stage_model stage (.aclk, .turn_off, .target_mv(target), .vout_mv);
	initial
	begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end
	// ==========================================================
	// Tasks
	task complete_run;
		$display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task tmo;
		chk(32'h0000_0000, 32'h0000_0001);
		complete_run;
	endtask
	task wt(input int s, input logic v, input int n);
		for (int i = 0; obs[s] !== v; i++)
		begin
			if (i == n)
				tmo;
			@(negedge aclk);
		end
		@(posedge aclk);
		cmp_count++;
	endtask
	task hold(input int s, input logic v, input int n);
		repeat (n)
		begin
			@(negedge aclk);
			if (obs[s] !== v)
				chk(obs[s], v);
		end
		@(posedge aclk);
		cmp_count++;
	endtask
	// Both channels are offered at once; each valid drops on its own handshake edge.
	task bus(input bit w, input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
		bit b, ha, hw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= dv;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		b = 0;
		for (int i = 0; !b; i++)
		begin
			@(negedge aclk);
			if (i == 200)
				tmo;
			ha = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
			hw = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid || s_axi_rvalid;
			d = s_axi_rdata;
			if (b)
				chk(w ? s_axi_bresp : s_axi_rresp, er);
			@(posedge aclk);
			if (ha)
			begin
				s_axi_awvalid <= 1'h0;
				s_axi_arvalid <= 1'h0;
			end
			if (hw)
				s_axi_wvalid <= 1'h0;
			if (b)
			begin
				s_axi_bready <= 1'h0;
				s_axi_rready <= 1'h0;
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] dv);
		bus(1, a, dv, RESP_OKAY);
	endtask
	task rd(input logic [7:0] a);
		bus(0, a, 32'h0000_0000, RESP_OKAY);
	endtask
	// ==========================================================
	// Sequence
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		chk(turn_off, 1'h0);
		foreach (rd_list[k])
		begin
			rd(rd_list[k]);
			chk(d, 32'h0000_0000);
		end
		bus(0, 8'h40, 32'h0000_0000, RESP_SLVERR);
		bus(1, 8'h40, 32'h0000_0001, RESP_SLVERR);
		for (int k = 0; k < 5; k++)
		begin
			vset_mv <= rows[k].vs;
			wr(OFS_CTRL, 32'(rows[k].sel) << 7);
			rd(OFS_OV_LEVEL);
			chk(d, rows[k].ov);
			chk(overvoltage_trip, rows[k].ov);
		end
		vset_mv <= 16'h03E8;
		wr(OFS_CTRL, 32'h0000_0000);
		hold(1, 1'h0, 280);
		wt(1, 1'h1, 40);
		chk(irq, 1'h0);
		wr(OFS_IRQ_MASK, 32'h0000_0010);
		wt(2, 1'h1, 5);
		wr(OFS_IRQ_STAT, 32'h0000_001F);
		wt(2, 1'h0, 5);
		target <= 16'h03AC;
		wr(OFS_CTRL, 32'h0000_0004);
		hold(1, 1'h1, 280);
		wt(1, 1'h0, 40);
		wt(2, 1'h1, 5);
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		wt(2, 1'h0, 5);
		target <= 16'h02BC;
		hold(0, 1'h0, 280);
		wt(0, 1'h1, 40);
		target <= 16'h03E8;
		hold(0, 1'h1, 40);
		wt(0, 1'h0, 700);
		wr(OFS_CTRL, 32'h0000_000B);
		target <= 16'h0370;
		wt(0, 1'h1, 700);
		target <= 16'h03E8;
		hold(0, 1'h1, 320);
		rd(OFS_STATUS);
		chk(d & 32'h0000_00C1, 32'h0000_00C1);
		wr(OFS_CLEAR, 32'h0000_0001);
		wt(0, 1'h0, 10);
		hold(0, 1'h0, 20);
		wr(OFS_CTRL, 32'h0000_0000);
		temp_c <= 10'sh078;
		hold(0, 1'h0, 15);
		wt(0, 1'h1, 20);
		rd(OFS_IRQ_STAT);
		chk(d & 32'h0000_0008, 32'h0000_0000);
		repeat (320) @(posedge aclk);
		rd(OFS_STATUS);
		chk(d & 32'h0000_002C, 32'h0000_002C);
		temp_c <= 10'sh076;
		repeat (320) @(posedge aclk);
		rd(OFS_STATUS);
		chk(d & 32'h0000_0028, 32'h0000_0028);
		temp_c <= 10'sh06E;
		wt(0, 1'h0, 10);
		repeat (320) @(posedge aclk);
		rd(OFS_STATUS);
		chk(d & 32'h0000_0008, 32'h0000_0000);
		wr(OFS_CTRL, 32'h0000_0010);
		temp_c <= 10'sh078;
		wt(0, 1'h1, 40);
		temp_c <= 10'sh06E;
		hold(0, 1'h1, 500);
		wr(OFS_CLEAR, 32'h0000_0001);
		wt(0, 1'h0, 10);
		ramping_up <= 1'h1;
		target <= 16'h0514;
		hold(0, 1'h0, 400);
		wr(OFS_CTRL, 32'h0000_0060);
		wt(0, 1'h1, 320);
		hold(0, 1'h1, 320);
		rd(OFS_STATUS);
		chk(d & 32'h0000_00C2, 32'h0000_00C2);
		ramping_up <= 1'h0;
		target <= 16'h03E8;
		wr(OFS_CLEAR, 32'h0000_0001);
		wt(0, 1'h0, 10);
		wr(OFS_IRQ_MASK, 32'h0000_001F);
		wt(2, 1'h1, 5);
		aresetn <= 1'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		chk(irq, 1'h0);
		chk(turn_off, 1'h0);
		rd(OFS_IRQ_MASK);
		chk(d, 32'h0000_0000);
		complete_run;
	end
endmodule
